// File: verilog/config_set_manager.sv
// Purpose: Live parameter set with factory profiles, user slots and boot loading
// Assumes: Commands, writes and acquisition status come from logic on sys_clk_i
// Notes: Whole-set copies take one cycle; ready_o is low during reset and for the boot cycle
`timescale 1ns/1ps

// Summary of operation
// R1: Live set sits in flops that every system reset loads with the standard profile.
// R2: Host parameter writes change only the live set, which drives the camera.
// R3: Two factory profiles are constants and cannot be written.
// R4: Standard profile has low gain and all automatic functions off.
// R5: High-gain profile equals standard with gain six decibels higher.
// R6: Factory selector ships as standard and survives system reset.
// R7: Factory selector changes only while acquisition is idle.
// R8: Three user slots live in storage that system reset does not touch.
// R9: Save copies the live set, except the lookup table word, into the chosen user slot.
// R10: Lookup table word is never stored in a user slot.
// R11: Load overwrites the live set, except the lookup table word, from chosen slot or default profile.
// R12: Load is accepted only while acquisition is idle.
// R13: Boot selector holds user slot 1, 2, 3 or default.
// R14: After each reset the boot choice is copied into the live set.
// R15: Refused load or selector change leaves live set and selector unchanged.
module config_set_manager
	import cfgset_pkg::*;
(
	// Clock, enable and resets
	input wire logic sys_clk_i,
	input wire logic ce_i,
	input wire logic rst_b_i,
	input wire logic nv_init_b_i,
	// Acquisition status
	input wire logic acq_running_i,
	input wire logic acq_pending_i,
	// Host parameter access
	input wire logic param_wr_i,
	input wire logic [1:0] param_addr_i,
	input wire logic [PARAM_W-1:0] param_wdata_i,
	input wire logic [1:0] param_rd_addr_i,
	output logic [PARAM_W-1:0] param_rd_data_o,
	// Commands and selectors
	input wire logic [1:0] slot_target_select_i,
	input wire logic store_live_cmd_i,
	input wire logic restore_to_live_cmd_i,
	input wire logic factory_sel_wr_i,
	input wire logic factory_profile_select_i,
	input wire logic boot_sel_wr_i,
	input wire logic [1:0] boot_profile_select_i,
	// Status
	output logic ready_o,
	output logic cmd_reject_o,
	output logic factory_profile_o,
	output logic [1:0] boot_profile_o,
	output logic [PARAM_W-1:0] live_gain_o,
	output logic [PARAM_W-1:0] live_auto_o
);

	typedef enum logic {ST_BOOT, ST_RUN} state_e;

	state_e state_q;
	pset_t live_q;
	pset_t [NUM_USER_SLOTS-1:0] slots;
	logic fact_sel;
	logic [1:0] boot_sel;
	logic idle;
	logic running;
	logic load_ok;
	logic fact_ok;
	logic save_ok;
	logic rejected;
	logic cmd_reject_q;
	logic [PARAM_W-1:0] rd_data_q;

	// Default maps to whichever factory profile is selected
	function automatic pset_t fetch_set(input logic [1:0] sel, input logic fact,
			input pset_t [NUM_USER_SLOTS-1:0] s);
		pset_t r;
		r = factory_set(fact); // [R3]
		unique case (sel)
			SLOT_DEFAULT: r = factory_set(fact);
			SLOT_USER1: r = s[0];
			SLOT_USER2: r = s[1];
			SLOT_USER3: r = s[2];
		endcase
		return r;
	endfunction : fetch_set

	// ****************************************
	// Command qualification
	// ****************************************
	assign idle = !acq_running_i && !acq_pending_i;
	assign running = state_q == ST_RUN;
	assign load_ok = running && restore_to_live_cmd_i && idle; // [R12]
	assign fact_ok = running && factory_sel_wr_i && idle; // [R7]
	assign save_ok = running && store_live_cmd_i && slot_target_select_i != SLOT_DEFAULT; // [R9]
	assign rejected = running && !idle && (restore_to_live_cmd_i || factory_sel_wr_i); // [R15]

	cfgset_nv_store u_nv (
		.sys_clk_i(sys_clk_i),
		.ce_i(ce_i),
		.nv_init_b_i(nv_init_b_i),
		.slot_wr_i(save_ok),
		.slot_idx_i(slot_target_select_i),
		.slot_wdata_i(strip_lut(live_q, LUT_RESET)), // [R10]
		.fact_wr_i(fact_ok),
		.fact_wdata_i(factory_profile_select_i),
		.boot_wr_i(running && boot_sel_wr_i),
		.boot_wdata_i(boot_profile_select_i),
		.slots_o(slots),
		.fact_sel_o(fact_sel),
		.boot_sel_o(boot_sel)
	);

	// ****************************************
	// Boot sequencing
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= ST_BOOT;
		end else if (ce_i) begin
			state_q <= ST_RUN;
		end
	end

	// ****************************************
	// Live set
	// ****************************************
	// Load beats a same-cycle host write so the set stays coherent
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			live_q <= factory_set(FACT_STANDARD); // Volatile [R1]
		end else if (ce_i) begin
			if (state_q == ST_BOOT) begin
				live_q <= strip_lut(fetch_set(boot_sel, fact_sel, slots), LUT_RESET); // [R14]
			end else if (load_ok) begin
				live_q <= strip_lut(fetch_set(slot_target_select_i, fact_sel, slots), live_q[IDX_LUT]); // [R11]
			end else if (param_wr_i) begin
				live_q[param_addr_i] <= param_wdata_i; // [R2]
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_reject_q <= 1'b0;
		end else if (ce_i) begin
			cmd_reject_q <= rejected; // [R15]
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_data_q <= '0;
		end else if (ce_i) begin
			rd_data_q <= live_q[param_rd_addr_i];
		end
	end

	assign ready_o = running;
	assign cmd_reject_o = cmd_reject_q;
	assign param_rd_data_o = rd_data_q;
	assign factory_profile_o = fact_sel;
	assign boot_profile_o = boot_sel;
	assign live_gain_o = live_q[IDX_GAIN];
	assign live_auto_o = live_q[IDX_AUTO];

	// ****************************************
	// Checks
	// ****************************************
	boot_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R14]
		(state_q == ST_BOOT && ce_i) |=> (state_q == ST_RUN
			&& live_q == strip_lut(fetch_set($past(boot_sel), $past(fact_sel), $past(slots)), LUT_RESET)))
		else $error("boot set not copied into live set");

	load_apply_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R11]
		(ce_i && load_ok) |=> live_q[IDX_GAIN]
			== fetch_set($past(slot_target_select_i), $past(fact_sel), $past(slots))[IDX_GAIN])
		else $error("load did not copy gain");

	load_busy_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R12]
		(ce_i && running && restore_to_live_cmd_i && !idle && !param_wr_i) |=> $stable(live_q))
		else $error("load accepted during acquisition");

	fact_busy_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R7]
		(ce_i && factory_sel_wr_i && !idle) |=> $stable(fact_sel))
		else $error("factory selector changed while busy");

	reject_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R15]
		(ce_i && rejected) |=> cmd_reject_o ##1 (!ce_i || !$past(rejected) || cmd_reject_o))
		else $error("refused command not flagged");

	lut_kept_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R10]
		(ce_i && load_ok) |=> live_q[IDX_LUT] == $past(live_q[IDX_LUT]))
		else $error("load disturbed lookup table word");

	save_slot_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R9]
		(ce_i && save_ok) |=> slots[$past(slot_target_select_i) - 2'h1] == strip_lut($past(live_q), LUT_RESET))
		else $error("save did not replace slot");

	high_gain_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R5]
		(ce_i && load_ok && slot_target_select_i == SLOT_DEFAULT && fact_sel == FACT_HIGH_GAIN)
			|=> live_gain_o == PARAM_W'(STD_GAIN + GAIN_6DB_STEP) && live_auto_o == AUTO_ALL_OFF)
		else $error("high gain profile wrong");

	host_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R2]
		(ce_i && running && param_wr_i && !load_ok) |=> live_q[$past(param_addr_i)] == $past(param_wdata_i))
		else $error("host write lost");

	live_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R2]
		(ce_i && running && !load_ok && !param_wr_i) |=> $stable(live_q))
		else $error("live set changed without write or load");

	boot_sel_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R13]
		(ce_i && running && boot_sel_wr_i) |=> boot_sel == $past(boot_profile_select_i))
		else $error("boot selector write lost");

	fact_apply_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R7]
		(ce_i && fact_ok) |=> fact_sel == $past(factory_profile_select_i))
		else $error("factory selector write lost");

	reject_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R15]
		(ce_i && running && idle && (restore_to_live_cmd_i || factory_sel_wr_i)) |=> !cmd_reject_o)
		else $error("accepted command flagged as refused");

	save_default_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R9]
		(ce_i && running && store_live_cmd_i && slot_target_select_i == SLOT_DEFAULT) |=> $stable(slots))
		else $error("save to default touched a user slot");

endmodule : config_set_manager

// File: verilog/cfgset_pkg.sv
// Purpose: Shared constants and types for the configuration set manager
// Assumes: Parameter words are PARAM_W bits, one live set of NUM_PARAMS words
// Notes: Gain is coded in 1/8 dB steps, so six decibels is 48 steps
package cfgset_pkg;

	localparam int PARAM_W = 16;
	localparam int NUM_PARAMS = 4;
	localparam int NUM_USER_SLOTS = 3;

	// ****************************************
	// Word positions inside a parameter set
	// ****************************************
	localparam int IDX_GAIN = 0;
	localparam int IDX_AUTO = 1;
	localparam int IDX_BLACK = 2;
	localparam int IDX_LUT = 3;

	// ****************************************
	// Factory values
	// ****************************************
	localparam logic [PARAM_W-1:0] STD_GAIN = 16'h0010;
	localparam logic [PARAM_W-1:0] GAIN_6DB_STEP = 16'h0030;
	localparam logic [PARAM_W-1:0] AUTO_ALL_OFF = 16'h0000;
	localparam logic [PARAM_W-1:0] STD_BLACK = 16'h0020;
	localparam logic [PARAM_W-1:0] LUT_RESET = 16'h0000;

	// ****************************************
	// Selector codes
	// ****************************************
	localparam logic [1:0] SLOT_DEFAULT = 2'h0;
	localparam logic [1:0] SLOT_USER1 = 2'h1;
	localparam logic [1:0] SLOT_USER2 = 2'h2;
	localparam logic [1:0] SLOT_USER3 = 2'h3;
	localparam logic FACT_STANDARD = 1'h0;
	localparam logic FACT_HIGH_GAIN = 1'h1;
	localparam logic [1:0] BOOT_SEL_RESET = SLOT_DEFAULT;
	localparam logic FACT_SEL_RESET = FACT_STANDARD;

	typedef logic [NUM_PARAMS-1:0][PARAM_W-1:0] pset_t;

	function automatic pset_t factory_set(input logic high_gain);
		pset_t s;
		s = '0;
		s[IDX_GAIN] = high_gain ? PARAM_W'(STD_GAIN + GAIN_6DB_STEP) : STD_GAIN; // [R5]
		s[IDX_AUTO] = AUTO_ALL_OFF; // [R4]
		s[IDX_BLACK] = STD_BLACK;
		s[IDX_LUT] = LUT_RESET;
		return s;
	endfunction : factory_set

	// Lookup table word never travels through stored sets
	function automatic pset_t strip_lut(input pset_t s, input logic [PARAM_W-1:0] lut);
		pset_t r;
		r = s;
		r[IDX_LUT] = lut;
		return r;
	endfunction : strip_lut

endpackage : cfgset_pkg

// File: verilog/cfgset_nv_store.sv
// Purpose: Non-volatile store of three user slots and the two persistent selectors
// Assumes: nv_init_b_i is the shipping initialisation only, never the system reset
// Notes: Survives rst_b_i because it does not see it
`timescale 1ns/1ps
module cfgset_nv_store
	import cfgset_pkg::*;
(
	// Clock and shipping init
	input wire logic sys_clk_i,
	input wire logic ce_i,
	input wire logic nv_init_b_i,
	// Slot write
	input wire logic slot_wr_i,
	input wire logic [1:0] slot_idx_i,
	input wire pset_t slot_wdata_i,
	// Selector writes
	input wire logic fact_wr_i,
	input wire logic fact_wdata_i,
	input wire logic boot_wr_i,
	input wire logic [1:0] boot_wdata_i,
	// Stored contents
	output pset_t [NUM_USER_SLOTS-1:0] slots_o,
	output logic fact_sel_o,
	output logic [1:0] boot_sel_o
);

	pset_t [NUM_USER_SLOTS-1:0] slots_q; // [R8]
	logic fact_sel_q;
	logic [1:0] boot_sel_q;

	genvar g;
	generate
		for (g = 0; g < NUM_USER_SLOTS; g++) begin : g_slot
			always_ff @(posedge sys_clk_i or negedge nv_init_b_i) begin
				if (!nv_init_b_i) begin
					slots_q[g] <= factory_set(FACT_STANDARD);
				end else if (ce_i && slot_wr_i && slot_idx_i == 2'(g + 1)) begin
					slots_q[g] <= slot_wdata_i; // Whole slot replaced [R9]
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk_i or negedge nv_init_b_i) begin
		if (!nv_init_b_i) begin
			fact_sel_q <= FACT_SEL_RESET; // As shipped [R6]
		end else if (ce_i && fact_wr_i) begin
			fact_sel_q <= fact_wdata_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nv_init_b_i) begin
		if (!nv_init_b_i) begin
			boot_sel_q <= BOOT_SEL_RESET;
		end else if (ce_i && boot_wr_i) begin
			boot_sel_q <= boot_wdata_i; // [R13]
		end
	end

	assign slots_o = slots_q;
	assign fact_sel_o = fact_sel_q;
	assign boot_sel_o = boot_sel_q;

endmodule : cfgset_nv_store

// File: tb/cfg_host_model.sv
// Purpose: Host software model issuing parameter writes, selectors and set commands
// Assumes: Requests are driven 1 ns after the rising edge of sys_clk_i
// Notes: Command pulses last exactly one cycle; selectors stay put afterwards
`timescale 1ns/1ps
module cfg_host_model
	import cfgset_pkg::*;
(
	// Clock
	input wire logic sys_clk_i,
	// Parameter writes
	output logic param_wr_o,
	output logic [1:0] param_addr_o,
	output logic [PARAM_W-1:0] param_wdata_o,
	// Commands and selectors
	output logic [1:0] slot_sel_o,
	output logic store_o,
	output logic restore_o,
	output logic fact_wr_o,
	output logic fact_sel_o,
	output logic boot_wr_o,
	output logic [1:0] boot_sel_o
);
	initial begin
		{param_wr_o, param_addr_o, param_wdata_o, slot_sel_o, store_o} = '0;
		{restore_o, fact_wr_o, fact_sel_o, boot_wr_o, boot_sel_o} = '0;
	end

	// Kind 0 write, 1 save, 2 load, 3 factory select, 4 boot select
	task automatic issue(input int kind, input logic [1:0] sel, input logic [PARAM_W-1:0] data);
		@(posedge sys_clk_i);
		#1;
		case (kind)
			0: {param_addr_o, param_wdata_o, param_wr_o} = {sel, data, 1'b1};
			1: {slot_sel_o, store_o} = {sel, 1'b1};
			2: {slot_sel_o, restore_o} = {sel, 1'b1};
			3: {fact_sel_o, fact_wr_o} = {data[0], 1'b1};
			default: {boot_sel_o, boot_wr_o} = {sel, 1'b1};
		endcase
		@(posedge sys_clk_i);
		#1;
		{param_wr_o, store_o, restore_o, fact_wr_o, boot_wr_o} = '0;
	endtask : issue
endmodule : cfg_host_model

// File: tb/config_set_manager_tb.sv
// Purpose: Self-checking bench for the configuration set manager
// Assumes: 40 MHz clock, inputs change 1 ns after the rising edge
// Notes: Acquisition status is driven here; commands come from the host model
`timescale 1ns/1ps
module config_set_manager_tb;
	import cfgset_pkg::*;
	logic sys_clk_i = 1'b0, ce_i = 1'b1, rst_b_i = 1'b0, nv_init_b_i = 1'b0;
	logic acq_running_i = 1'b0, acq_pending_i = 1'b0, param_wr_i, store_live_cmd_i, restore_to_live_cmd_i;
	logic factory_sel_wr_i, factory_profile_select_i, boot_sel_wr_i, ready_o, cmd_reject_o, factory_profile_o;
	logic [1:0] param_addr_i, param_rd_addr_i = 2'h0, slot_target_select_i, boot_profile_select_i, boot_profile_o;
	logic [PARAM_W-1:0] param_wdata_i, param_rd_data_o, live_gain_o, live_auto_o;
	int n_fail = 0, total_checks = 0;

	always #12.5 sys_clk_i = ~sys_clk_i;

	config_set_manager i_dut (.sys_clk_i, .ce_i, .rst_b_i, .nv_init_b_i, .acq_running_i, .acq_pending_i,
		.param_wr_i, .param_addr_i, .param_wdata_i, .param_rd_addr_i, .param_rd_data_o, .slot_target_select_i,
		.store_live_cmd_i, .restore_to_live_cmd_i, .factory_sel_wr_i, .factory_profile_select_i, .boot_sel_wr_i,
		.boot_profile_select_i, .ready_o, .cmd_reject_o, .factory_profile_o, .boot_profile_o, .live_gain_o,
		.live_auto_o);

	cfg_host_model i_host (.sys_clk_i, .param_wr_o(param_wr_i), .param_addr_o(param_addr_i),
		.param_wdata_o(param_wdata_i), .slot_sel_o(slot_target_select_i), .store_o(store_live_cmd_i),
		.restore_o(restore_to_live_cmd_i), .fact_wr_o(factory_sel_wr_i), .fact_sel_o(factory_profile_select_i),
		.boot_wr_o(boot_sel_wr_i), .boot_sel_o(boot_profile_select_i));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic results;
		$display("Checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [PARAM_W-1:0] seen, input logic [PARAM_W-1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Shipping init only when asked; it would wipe the slots otherwise
	task automatic do_reset(input logic nv);
		int k;
		@(posedge sys_clk_i);
		#1;
		rst_b_i = 1'b0;
		nv_init_b_i = ~nv;
		repeat (8) @(posedge sys_clk_i);
		#1;
		rst_b_i = 1'b1;
		nv_init_b_i = 1'b1;
		k = 0;
		while (ready_o !== 1'b1 && k < 20) begin
			@(posedge sys_clk_i);
			#1;
			k++;
		end
		if (ready_o !== 1'b1) begin
			n_fail++;
			results();
		end
	endtask : do_reset

	task automatic rd(input logic [1:0] a, input logic [PARAM_W-1:0] exp);
		param_rd_addr_i = a;
		@(posedge sys_clk_i);
		#1;
		chk(param_rd_data_o, exp);
	endtask : rd

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_boot;
		chk(live_gain_o, STD_GAIN);
		chk(live_auto_o, AUTO_ALL_OFF);
		chk(16'(factory_profile_o), 16'(FACT_STANDARD));
		chk(16'(boot_profile_o), 16'(BOOT_SEL_RESET));
		rd(2'(IDX_BLACK), STD_BLACK);
	endtask : t_boot

	task automatic t_save_load;
		i_host.issue(0, 2'(IDX_GAIN), 16'h1234);
		chk(live_gain_o, 16'h1234);
		i_host.issue(0, 2'(IDX_LUT), 16'h00AB);
		i_host.issue(1, SLOT_USER1, 16'h0);
		i_host.issue(0, 2'(IDX_GAIN), 16'h5555);
		i_host.issue(2, SLOT_USER1, 16'h0);
		chk(live_gain_o, 16'h1234);
		rd(2'(IDX_LUT), 16'h00AB);
		i_host.issue(0, 2'(IDX_GAIN), 16'h2222);
		i_host.issue(1, SLOT_DEFAULT, 16'h0);
		i_host.issue(2, SLOT_USER1, 16'h0);
		chk(live_gain_o, 16'h1234);
	endtask : t_save_load

	task automatic t_busy;
		acq_running_i = 1'b1;
		i_host.issue(0, 2'(IDX_GAIN), 16'h7777);
		i_host.issue(2, SLOT_USER1, 16'h0);
		chk(16'(cmd_reject_o), 16'h1);
		chk(live_gain_o, 16'h7777);
		{acq_running_i, acq_pending_i} = 2'b01;
		i_host.issue(3, 2'h0, 16'h1);
		chk(16'(cmd_reject_o), 16'h1);
		chk(16'(factory_profile_o), 16'(FACT_STANDARD));
		acq_pending_i = 1'b0;
	endtask : t_busy

	task automatic t_high_gain;
		i_host.issue(3, 2'h0, 16'(FACT_HIGH_GAIN));
		chk(16'(factory_profile_o), 16'(FACT_HIGH_GAIN));
		chk(16'(cmd_reject_o), 16'h0);
		i_host.issue(2, SLOT_DEFAULT, 16'h0);
		chk(live_gain_o, STD_GAIN + GAIN_6DB_STEP);
		chk(live_auto_o, AUTO_ALL_OFF);
	endtask : t_high_gain

	task automatic t_reboot;
		i_host.issue(4, SLOT_USER1, 16'h0);
		chk(16'(boot_profile_o), 16'(SLOT_USER1));
		do_reset(1'b0);
		chk(live_gain_o, 16'h1234);
		chk(16'(factory_profile_o), 16'(FACT_HIGH_GAIN));
		rd(2'(IDX_LUT), LUT_RESET);
		i_host.issue(4, SLOT_DEFAULT, 16'h0);
		chk(16'(boot_profile_o), 16'(SLOT_DEFAULT));
		do_reset(1'b0);
		chk(live_gain_o, STD_GAIN + GAIN_6DB_STEP);
		chk(live_auto_o, AUTO_ALL_OFF);
	endtask : t_reboot

	initial begin
		do_reset(1'b1);
		t_boot();
		t_save_load();
		t_busy();
		t_high_gain();
		t_reboot();
		results();
	end
endmodule : config_set_manager_tb
